// *** charger_third_trigger_source_cfg.svh ***
// Offsets, field positions, codes, reset values and timing for stage three.
`ifndef CHARGER_THIRD_TRIGGER_SOURCE_CFG_SVH
`define CHARGER_THIRD_TRIGGER_SOURCE_CFG_SVH

// ----------------------------------------------------------------------
// Register map and reset values
// ----------------------------------------------------------------------
`define TRIGGER_CONFIG_OFFSET 8'h39
`define REPLY_CONFIG_OFFSET   8'h3a
`define TRIGGER_CONFIG_RESET  8'h00
`define REPLY_CONFIG_RESET    8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TIMER_MODE_BIT   6
`define DELAY_SEL_MSB    5
`define DELAY_SEL_LSB    3
`define SOURCE_MSB       2
`define SOURCE_LSB       0
`define MAGNITUDE_MSB    7
`define MAGNITUDE_LSB    4
`define SELECT_MSB       3
`define SELECT_LSB       0

// ----------------------------------------------------------------------
// Stimulus sources and reply codes
// ----------------------------------------------------------------------
`define SRC_BUS_READY    3'h0
`define SRC_PLUS_ABOVE   3'h1
`define SRC_PLUS_WINDOW  3'h2
`define SRC_MINUS_ABOVE  3'h3
`define SRC_RSVD_A       3'h4
`define SRC_RSVD_B       3'h5
`define SRC_PLUS_ABOVE_B 3'h6
`define SRC_BUS_PRESENT  3'h7
`define REPLY_CLEAR      4'h0
`define REPLY_V_PLUS     4'h1
`define REPLY_V_MINUS    4'h2
`define REPLY_V_BOTH     4'h3
`define REPLY_R_PLUS     4'h4
`define REPLY_RSVD_A     4'h5
`define REPLY_D_PLUS     4'h6
`define REPLY_R_MINUS    4'h7
`define REPLY_RSVD_B     4'h8
`define REPLY_D_MINUS    4'h9
`define REPLY_BRIDGE     4'ha
`define REPLY_RSVD_C     4'hb
`define REPLY_D_BOTH     4'hc
`define REPLY_R_BOTH     4'hd
`define REPLY_PD_CTRL_A  4'he
`define REPLY_PD_CTRL_B  4'hf
`define MAGNITUDE_RSVD   4'hf

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_HZ           25000000
`define MS_PER_S         1000
`define DELAY_MS_0       7'd0
`define DELAY_MS_1       7'd1
`define DELAY_MS_2       7'd5
`define DELAY_MS_3       7'd10
`define DELAY_MS_4       7'd20
`define DELAY_MS_5       7'd40
`define DELAY_MS_6       7'd80
`define DELAY_MS_7       7'd100
`endif

// *** charger_third_trigger_source_pkg.sv ***
// Types shared by the stage-three stimulus and response logic.
package charger_third_trigger_source_pkg;
   typedef enum logic [2:0] {
      LINE_OPEN, LINE_RESET_PULLDOWN, LINE_VOLTAGE, LINE_RES_TO_GND,
      LINE_DIVIDER
   } line_mode_t;

   typedef struct packed {
      line_mode_t mode;
      logic [3:0] magnitude;
   } line_drive_t;

   typedef struct packed {
      logic bus_ready;
      logic bus_present;
      logic plus_above_thr;
      logic plus_above_floor;
      logic minus_above_thr;
   } line_sense_t;

   typedef struct packed {
      logic       third_timer_mode;
      logic [2:0] third_trigger_delay_sel;
      logic [2:0] third_trigger_source;
   } trigger_cfg_t;

   typedef struct packed {
      logic [3:0] third_reply_magnitude;
      logic [3:0] third_reply_select;
   } reply_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT_TRIGGER, ST_DELAY, ST_HOLD, ST_HOLD_WAIT
   } stage_state_t;
endpackage

// *** sense_sync.sv ***
// Three-stage synchroniser for the analog comparator inputs.
`timescale 1ns/1ps
`default_nettype none
module sense_sync #(
   parameter int WIDTH = 5
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] raw_in,
   output logic      [WIDTH-1:0] clean_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] out;
   } sync_t;

   sync_t sync_reg;
   sync_t sync_next;

   // ----------------------------------------------------------------------
   // Shift chain; a bit moves only once stages two and three agree.
   // ----------------------------------------------------------------------
   always_comb begin
      sync_next    = sync_reg;
      sync_next.s1 = raw_in;
      sync_next.s2 = sync_reg.s1;
      sync_next.s3 = sync_reg.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (sync_reg.s2[i] == sync_reg.s3[i]) begin
            sync_next.out[i] = sync_reg.s3[i];
         end
      end
   end

   // Register the whole chain.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign clean_out = sync_reg.out;
endmodule
`default_nettype wire

// *** stim_timer.sv ***
// Millisecond timer for the stimulus delay and hold time.
`timescale 1ns/1ps
`default_nettype none
module stim_timer #(
   parameter int CYCLES_PER_MS = 25000
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic [6:0] duration_ms,
   output logic            expired
);
   localparam int SUB_W = $clog2(CYCLES_PER_MS);

   typedef struct packed {
      logic             running;
      logic [6:0]       ms_left;
      logic [SUB_W-1:0] sub;
      logic             expired;
   } timer_t;

   timer_t tmr_reg;
   timer_t tmr_next;

   // ----------------------------------------------------------------------
   // Count whole milliseconds; a zero duration expires on the next edge.
   // ----------------------------------------------------------------------
   always_comb begin
      tmr_next         = tmr_reg;
      tmr_next.expired = 1'b0;
      if (start) begin
         tmr_next.ms_left = duration_ms;
         tmr_next.sub     = SUB_W'(CYCLES_PER_MS - 1);
         tmr_next.running = (duration_ms != 7'd0);
         tmr_next.expired = (duration_ms == 7'd0);
      end else if (tmr_reg.running) begin
         if (tmr_reg.sub != '0) begin
            tmr_next.sub = tmr_reg.sub - SUB_W'(1);
         end else if (tmr_reg.ms_left == 7'd1) begin
            tmr_next.running = 1'b0;
            tmr_next.expired = 1'b1;
         end else begin
            tmr_next.ms_left = tmr_reg.ms_left - 7'd1;
            tmr_next.sub     = SUB_W'(CYCLES_PER_MS - 1);
         end
      end
   end

   // Register the timer state.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tmr_reg <= '0;
      end else begin
         tmr_reg <= tmr_next;
      end
   end

   assign expired = tmr_reg.expired;
endmodule
`default_nettype wire

// *** charger_third_trigger_source.sv ***
// Stage-three stimulus detection, timing and response steering.
`timescale 1ns/1ps
`default_nettype none
`include "charger_third_trigger_source_cfg.svh"
module charger_third_trigger_source
   import charger_third_trigger_source_pkg::*;
#(
   parameter int CYCLES_PER_MS = `CLK_HZ / `MS_PER_S
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        load_trigger_strobe,
   input  wire logic [7:0]  load_trigger_data,
   input  wire logic        load_reply_strobe,
   input  wire logic [7:0]  load_reply_data,
   input  wire logic        emu_reset,
   input  wire logic        stage_start,
   input  wire line_sense_t sense_raw,
   output logic      [7:0]  third_trigger_config,
   output logic      [7:0]  third_reply_config,
   output line_drive_t      plus_line_out,
   output line_drive_t      minus_line_out,
   output logic             line_bridge_on,
   output logic             threshold_in_use,
   output logic             stage_busy,
   output logic             stage_done
);
   typedef struct packed {
      line_drive_t plus;
      line_drive_t minus;
      logic        bridge;
   } lines_t;

   typedef struct packed {
      logic on_plus;
      logic on_minus;
      logic on_bridge;
   } targets_t;

   typedef struct packed {
      stage_state_t state;
      trigger_cfg_t trig;
      reply_cfg_t   reply;
      lines_t       lines;
      logic         done;
   } core_t;

   core_t       core_reg;
   core_t       core_next;
   line_sense_t sense;
   logic        trigger_hit;
   logic        timer_start;
   logic        timer_expired;
   logic [6:0]  delay_ms;

   // ----------------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------------

   function automatic logic [6:0] delay_of(input logic [2:0] sel);
      logic [6:0] ms;
      ms = `DELAY_MS_0;
      case (sel)
         3'h1: ms = `DELAY_MS_1;
         3'h2: ms = `DELAY_MS_2;
         3'h3: ms = `DELAY_MS_3;
         3'h4: ms = `DELAY_MS_4;
         3'h5: ms = `DELAY_MS_5;
         3'h6: ms = `DELAY_MS_6;
         3'h7: ms = `DELAY_MS_7;
         default: ms = `DELAY_MS_0;
      endcase
      return ms;
   endfunction

   // Which lines a reply code acts on; shared by apply and removal.
   function automatic targets_t targets_of(input logic [3:0] sel);
      targets_t t;
      t = '0;
      case (sel)
         `REPLY_V_PLUS, `REPLY_R_PLUS, `REPLY_D_PLUS: t.on_plus = 1'b1;
         `REPLY_V_MINUS, `REPLY_R_MINUS, `REPLY_D_MINUS: t.on_minus = 1'b1;
         `REPLY_V_BOTH, `REPLY_R_BOTH, `REPLY_D_BOTH: begin
            t.on_plus  = 1'b1;
            t.on_minus = 1'b1;
         end
         `REPLY_BRIDGE: t.on_bridge = 1'b1;
         default: t = '0;
      endcase
      return t;
   endfunction

   // Line mode that a reply code places on its targets.
   function automatic line_mode_t mode_of(input logic [3:0] sel);
      line_mode_t m;
      m = LINE_OPEN;
      case (sel)
         `REPLY_V_PLUS, `REPLY_V_MINUS, `REPLY_V_BOTH: m = LINE_VOLTAGE;
         `REPLY_R_PLUS, `REPLY_R_MINUS, `REPLY_R_BOTH: m = LINE_RES_TO_GND;
         `REPLY_D_PLUS, `REPLY_D_MINUS, `REPLY_D_BOTH: m = LINE_DIVIDER;
         default: m = LINE_OPEN;
      endcase
      return m;
   endfunction

   // Drop a reset pull-down from a line, leave anything else alone.
   function automatic line_drive_t drop_pulldown(input line_drive_t d);
      line_drive_t o;
      o = d;
      if (d.mode == LINE_RESET_PULLDOWN) begin
         o = '{mode: LINE_OPEN, magnitude: 4'h0};
      end
      return o;
   endfunction

   // Compute the line state after applying the programmed reply.
   function automatic lines_t apply_reply(input lines_t cur,
                                          input reply_cfg_t rp,
                                          input logic [2:0] src);
      lines_t      n;
      targets_t    t;
      line_drive_t d;
      n = cur;
      t = targets_of(rp.third_reply_select);
      d = '{mode: mode_of(rp.third_reply_select),
            magnitude: rp.third_reply_magnitude};
      if (t.on_plus) begin
         n.plus = d;
      end
      if (t.on_minus) begin
         n.minus = d;
      end
      if (t.on_bridge) begin
         n.bridge = 1'b1;
      end
      // with a one-line reply, the untouched pin keeps its pull-down only on source 000
      if ((t.on_plus ^ t.on_minus) && src != `SRC_BUS_READY) begin
         if (t.on_plus) begin
            n.minus = drop_pulldown(cur.minus);
         end else begin
            n.plus = drop_pulldown(cur.plus);
         end
      end
      if (rp.third_reply_select == `REPLY_CLEAR) begin
         n = '0;
      end
      // pull-down control replies act only on source 111
      if ((rp.third_reply_select == `REPLY_PD_CTRL_A ||
           rp.third_reply_select == `REPLY_PD_CTRL_B) &&
          src == `SRC_BUS_PRESENT) begin
         n.plus  = drop_pulldown(cur.plus);
         n.minus = drop_pulldown(cur.minus);
      end
      return n;
   endfunction

   // Remove what a reply placed, once its hold time is over.
   function automatic lines_t remove_reply(input lines_t cur,
                                           input reply_cfg_t rp);
      lines_t   n;
      targets_t t;
      n = cur;
      t = targets_of(rp.third_reply_select);
      if (t.on_plus) begin
         n.plus = '0;
      end
      if (t.on_minus) begin
         n.minus = '0;
      end
      if (t.on_bridge) begin
         n.bridge = 1'b0;
      end
      return n;
   endfunction

   // ----------------------------------------------------------------------
   // Comparator inputs and timer
   // ----------------------------------------------------------------------

   // The comparators sit in the analog domain, so they are synchronised.
   sense_sync #(
      .WIDTH($bits(line_sense_t))
   ) u_sync (
      .clk      (clk),
      .rst      (rst),
      .raw_in   (sense_raw),
      .clean_out(sense)
   );

   // Stimulus decode by source code.
   always_comb begin
      trigger_hit = 1'b0;
      case (core_reg.trig.third_trigger_source)
         // supply ready ahead of the power switch
         `SRC_BUS_READY: trigger_hit = sense.bus_ready;
         `SRC_PLUS_ABOVE, `SRC_PLUS_ABOVE_B:
            trigger_hit = sense.plus_above_thr;
         // window between fixed floor and threshold, D+ only
         `SRC_PLUS_WINDOW:
            trigger_hit = !sense.plus_above_thr && sense.plus_above_floor;
         `SRC_MINUS_ABOVE: trigger_hit = sense.minus_above_thr;
         // supply present after the power switch closed
         `SRC_BUS_PRESENT: trigger_hit = sense.bus_present;
         default: trigger_hit = 1'b0;
      endcase
   end

   assign delay_ms    = delay_of(core_reg.trig.third_trigger_delay_sel);
   assign timer_start = (core_reg.state == ST_WAIT_TRIGGER) && trigger_hit;

   stim_timer #(
      .CYCLES_PER_MS(CYCLES_PER_MS)
   ) u_timer (
      .clk        (clk),
      .rst        (rst),
      .start      (timer_start),
      .duration_ms(delay_ms),
      .expired    (timer_expired)
   );

   // ----------------------------------------------------------------------
   // Configuration loads and stage sequencing
   // ----------------------------------------------------------------------
   always_comb begin
      core_next      = core_reg;
      core_next.done = 1'b0;
      // reserved source codes are refused, other fields still load
      if (load_trigger_strobe) begin
         core_next.trig.third_timer_mode =
            load_trigger_data[`TIMER_MODE_BIT];
         core_next.trig.third_trigger_delay_sel =
            load_trigger_data[`DELAY_SEL_MSB:`DELAY_SEL_LSB];
         if (load_trigger_data[`SOURCE_MSB:`SOURCE_LSB] != `SRC_RSVD_A &&
             load_trigger_data[`SOURCE_MSB:`SOURCE_LSB] != `SRC_RSVD_B) begin
            core_next.trig.third_trigger_source =
               load_trigger_data[`SOURCE_MSB:`SOURCE_LSB];
         end
      end
      // reserved reply and magnitude codes are refused per field
      if (load_reply_strobe) begin
         if (load_reply_data[`SELECT_MSB:`SELECT_LSB] != `REPLY_RSVD_A &&
             load_reply_data[`SELECT_MSB:`SELECT_LSB] != `REPLY_RSVD_B &&
             load_reply_data[`SELECT_MSB:`SELECT_LSB] != `REPLY_RSVD_C) begin
            core_next.reply.third_reply_select =
               load_reply_data[`SELECT_MSB:`SELECT_LSB];
         end
         // magnitude 1111 is reserved in every table
         if (load_reply_data[`MAGNITUDE_MSB:`MAGNITUDE_LSB] !=
             `MAGNITUDE_RSVD) begin
            core_next.reply.third_reply_magnitude =
               load_reply_data[`MAGNITUDE_MSB:`MAGNITUDE_LSB];
         end
      end

      case (core_reg.state)
         ST_IDLE: begin
            if (stage_start) begin
               core_next.state = ST_WAIT_TRIGGER;
            end
         end
         ST_WAIT_TRIGGER: begin
            if (trigger_hit) begin
               // hold mode applies the reply on detection
               if (core_reg.trig.third_timer_mode) begin
                  core_next.lines = apply_reply(core_reg.lines,
                     core_reg.reply, core_reg.trig.third_trigger_source);
                  core_next.state = ST_HOLD;
               end else begin
                  core_next.state = ST_DELAY;
               end
            end
         end
         ST_DELAY: begin
            // delay mode applies the reply when the time is up
            if (timer_expired) begin
               core_next.lines = apply_reply(core_reg.lines,
                  core_reg.reply, core_reg.trig.third_trigger_source);
               core_next.state = ST_IDLE;
               core_next.done  = 1'b1;
            end
         end
         ST_HOLD: begin
            if (timer_expired) begin
               // supply sources never wait for removal
               if (core_reg.trig.third_trigger_source == `SRC_BUS_READY ||
                   core_reg.trig.third_trigger_source == `SRC_BUS_PRESENT)
               begin
                  core_next.state = ST_IDLE;
                  core_next.done  = 1'b1;
               end else if (!trigger_hit) begin
                  // remove reply once the stimulus has gone
                  core_next.lines = remove_reply(core_reg.lines,
                                                 core_reg.reply);
                  core_next.state = ST_IDLE;
                  core_next.done  = 1'b1;
               end else begin
                  core_next.state = ST_HOLD_WAIT;
               end
            end
         end
         ST_HOLD_WAIT: begin
            // reply stays until the stimulus goes away
            if (!trigger_hit) begin
               core_next.lines = remove_reply(core_reg.lines,
                                              core_reg.reply);
               core_next.state = ST_IDLE;
               core_next.done  = 1'b1;
            end
         end
         default: core_next.state = ST_IDLE;
      endcase

      // Emulation reset wins: both pull-downs on, any stage abandoned.
      if (emu_reset) begin
         core_next.lines.plus  = '{mode: LINE_RESET_PULLDOWN,
                                   magnitude: 4'h0};
         core_next.lines.minus = '{mode: LINE_RESET_PULLDOWN,
                                   magnitude: 4'h0};
         core_next.lines.bridge = 1'b0;
         core_next.state        = ST_IDLE;
         core_next.done         = 1'b0;
      end
   end

   // configuration clears to zero at reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_reg <= '0;
      end else begin
         core_reg <= core_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------

   assign third_trigger_config = {1'b0, core_reg.trig};
   assign third_reply_config   = core_reg.reply;
   assign plus_line_out        = core_reg.lines.plus;
   assign minus_line_out       = core_reg.lines.minus;
   assign line_bridge_on       = core_reg.lines.bridge;
   assign stage_busy           = (core_reg.state != ST_IDLE);
   assign stage_done           = core_reg.done;
   assign threshold_in_use =
      core_reg.trig.third_trigger_source != `SRC_BUS_READY &&
      core_reg.trig.third_trigger_source != `SRC_BUS_PRESENT;
endmodule
`default_nettype wire

// *** charger_third_trigger_source_monitor.sv ***
// Port checker for the stage-three stimulus and response block.
`timescale 1ns/1ps
`default_nettype none
module charger_third_trigger_source_mon
   import charger_third_trigger_source_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        load_trigger_strobe,
   input wire logic [7:0]  load_trigger_data,
   input wire logic        load_reply_strobe,
   input wire logic [7:0]  load_reply_data,
   input wire logic        stage_start,
   input wire logic [7:0]  third_trigger_config,
   input wire logic [7:0]  third_reply_config,
   input wire line_drive_t plus_line_out,
   input wire line_drive_t minus_line_out,
   input wire logic        line_bridge_on,
   input wire logic        threshold_in_use,
   input wire logic        stage_busy,
   input wire logic        stage_done
);
   // ------
   // Properties
   // ------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_arm;
      stage_start && !stage_busy;
   endsequence
   sequence s_run;
      stage_busy [*2];
   endsequence
   property p_arm; s_arm |=> s_run; endproperty
   a_arm: assert property (p_arm) else $error("start not taken");
   property p_src_load;
      load_trigger_strobe && load_trigger_data[2:1] != 2'b10
      |=> third_trigger_config == {1'b0, $past(load_trigger_data[6:0])};
   endproperty
   a_src_load: assert property (p_src_load) else $error("load bad");
   property p_src_rsvd;
      load_trigger_strobe && load_trigger_data[2:1] == 2'b10
      |=> $stable(third_trigger_config[2:0]);
   endproperty
   a_src_rsvd: assert property (p_src_rsvd) else $error("source taken");
   property p_sel_rsvd;
      load_reply_strobe && load_reply_data[3:0] inside {4'h5, 4'h8, 4'hb}
      |=> $stable(third_reply_config[3:0]);
   endproperty
   a_sel_rsvd: assert property (p_sel_rsvd) else $error("reply taken");
   property p_mag_rsvd;
      load_reply_strobe && load_reply_data[7:4] == 4'hf
      |=> $stable(third_reply_config[7:4]);
   endproperty
   a_mag_rsvd: assert property (p_mag_rsvd) else $error("mag taken");
   property p_thr;
      threshold_in_use == !(third_trigger_config[2:0] inside {3'h0, 3'h7});
   endproperty
   a_thr: assert property (p_thr) else $error("threshold use wrong");
   property p_clear;
      stage_done && third_reply_config[3:0] == 4'h0 |-> !line_bridge_on &&
         plus_line_out.mode == LINE_OPEN && minus_line_out.mode == LINE_OPEN;
   endproperty
   a_clear: assert property (p_clear) else $error("lines not clear");
   property p_bridge;
      stage_done && !third_trigger_config[6] &&
         third_reply_config[3:0] == 4'ha |-> line_bridge_on;
   endproperty
   a_bridge: assert property (p_bridge) else $error("bridge off");
endmodule
bind charger_third_trigger_source charger_third_trigger_source_mon u_mon (.clk(clk), .rst(rst),
   .load_trigger_strobe(load_trigger_strobe),
   .load_trigger_data(load_trigger_data),
   .load_reply_strobe(load_reply_strobe), .load_reply_data(load_reply_data),
   .stage_start(stage_start), .third_trigger_config(third_trigger_config),
   .third_reply_config(third_reply_config), .plus_line_out(plus_line_out),
   .minus_line_out(minus_line_out), .line_bridge_on(line_bridge_on),
   .threshold_in_use(threshold_in_use), .stage_busy(stage_busy),
   .stage_done(stage_done));
`default_nettype wire

// *** portable_device.sv ***
// Model of the attached device's line levels seen by the comparators.
`timescale 1ns/1ps
`default_nettype none
module portable_device
   import charger_third_trigger_source_pkg::*;
(
   input  wire logic        clk,
   input  wire line_sense_t want,
   output var line_sense_t  sense_raw
);
   // Lines settle one clock after the device moves them.
   always_ff @(posedge clk) begin
      sense_raw <= want;
   end
endmodule
`default_nettype wire

// *** test_charger_third_trigger_source.sv ***
// Self-checking bench for the stage-three stimulus and response block.
`timescale 1ns/1ps
`default_nettype none
module test_charger_third_trigger_source
   import charger_third_trigger_source_pkg::*;
;
   localparam int CPM = 4;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        tstb = 1'b0;
   logic        pstb = 1'b0;
   logic        emu = 1'b0;
   logic        start = 1'b0;
   logic [7:0]  tdat = 8'h00;
   logic [7:0]  rdat = 8'h00;
   line_sense_t want = '0;
   line_sense_t sense;
   logic [7:0]  tcfg, rcfg, et, er;
   line_drive_t pl, ml;
   logic        bridge, busy, done;
   logic [31:0] seed = 32'h3d47;
   logic [3:0]  mag;
   logic [2:0]  src;
   logic [5:0]  em;
   int          fail_count = 0;
   int          samples_checked = 0;
   int          i, n, d;
   logic [3:0]  sels [13] = '{0, 1, 2, 3, 4, 6, 7, 9, 10, 12, 13, 14, 15};
   logic [2:0]  srcs [6] = '{0, 1, 2, 3, 6, 7};
   charger_third_trigger_source #(.CYCLES_PER_MS(CPM)) u_dut (.clk(clk), .rst(rst),
      .load_trigger_strobe(tstb), .load_trigger_data(tdat),
      .load_reply_strobe(pstb), .load_reply_data(rdat), .emu_reset(emu),
      .stage_start(start), .sense_raw(sense), .third_trigger_config(tcfg),
      .third_reply_config(rcfg), .plus_line_out(pl), .minus_line_out(ml),
      .line_bridge_on(bridge), .threshold_in_use(), .stage_busy(busy),
      .stage_done(done));
   portable_device u_dev (.clk(clk), .want(want), .sense_raw(sense));
   always #20 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] exp_cfg(input logic [15:0] o, x);
      return {1'b0, x[14:11], x[10:9] == 2'b10 ? o[10:8] : x[10:8],
         x[7:4] == 4'hf ? o[7:4] : x[7:4],
         x[3:0] inside {4'h5, 4'h8, 4'hb} ? o[3:0] : x[3:0]};
   endfunction
   function automatic int ms(input logic [2:0] s);
      int t [8] = '{0, 1, 5, 10, 20, 40, 80, 100};
      return t[s];
   endfunction
   function automatic line_sense_t stim(input logic [2:0] s);
      case (s)
         3'h0: return 5'b10000;
         3'h7: return 5'b01000;
         3'h2: return 5'b00010;
         3'h3: return 5'b00001;
         default: return 5'b00110;
      endcase
   endfunction
   function automatic logic [5:0] exp_pair(input logic [3:0] s, logic [2:0] c);
      logic [2:0] o;
      o = (c == 3'h0) ? LINE_RESET_PULLDOWN : LINE_OPEN;
      case (s)
         4'h0: return {LINE_OPEN, LINE_OPEN};
         4'h1: return {LINE_VOLTAGE, o};
         4'h2: return {o, LINE_VOLTAGE};
         4'h3: return {LINE_VOLTAGE, LINE_VOLTAGE};
         4'h4: return {LINE_RES_TO_GND, o};
         4'h6: return {LINE_DIVIDER, o};
         4'h7: return {o, LINE_RES_TO_GND};
         4'h9: return {o, LINE_DIVIDER};
         4'hc: return {LINE_DIVIDER, LINE_DIVIDER};
         4'hd: return {LINE_RES_TO_GND, LINE_RES_TO_GND};
         default: return (c == 3'h7) ? 6'h00 : 6'h09;
      endcase
   endfunction
   task automatic cmp8(input string nm, input logic [7:0] e, g);
      samples_checked++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic load(input logic [7:0] t, r);
      @(negedge clk) {tstb, pstb, tdat, rdat} = {2'b11, t, r};
      @(negedge clk) {tstb, pstb} = 2'b00;
   endtask
   task automatic arm();
      @(negedge clk) emu = 1'b1;
      @(negedge clk) {emu, start} = 2'b01;
      @(negedge clk) start = 1'b0;
   endtask
   // Wait for done, or for voltage on D- when stop is set; a runout fails.
   task automatic wait_on(input logic stop);
      n = 0;
      while (!(stop && ml.mode === LINE_VOLTAGE) && done !== 1'b1 &&
             n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000) begin
         fail_count++;
         conclude();
      end
   endtask
   task conclude();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog sized well past the longest delay sweep.
   initial begin
      #800000;
      fail_count++;
      conclude();
   end
   // Main sequence: reset values, random loads, stage sweep, hold mode.
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      cmp8("trigger cfg", 8'h00, tcfg);
      cmp8("reply cfg", 8'h00, rcfg);
      cmp8("plus line", 8'h00, {1'b0, pl});
      for (i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         {et, er} = exp_cfg({tcfg, rcfg}, i == 0 ? 16'hfcf8 : seed[15:0]);
         load(i == 0 ? 8'hfc : seed[15:8], i == 0 ? 8'hf8 : seed[7:0]);
         cmp8("trigger cfg", et, tcfg);
         cmp8("reply cfg", er, rcfg);
      end
      for (i = 0; i < 13; i++) begin
         seed = lfsr(seed);
         src = srcs[i % 6];
         d = ms(i[2:0]);
         mag = (seed[3:0] == 4'hf) ? 4'h5 : seed[3:0];
         load({2'b00, i[2:0], src}, {mag, sels[i]});
         arm();
         want = stim(src);
         wait_on(1'b0);
         em = exp_pair(sels[i], src);
         cmp8("delay", 8'h01, {7'h0, n - d * CPM inside {[6:9]}});
         if (sels[i] == 4'ha) cmp8("bridge", 8'h01, {7'h0, bridge});
         else cmp8("lines", 8'(em), 8'({pl.mode, ml.mode}));
         if (em[5:3] == LINE_VOLTAGE) begin
            cmp8("mag", 8'(mag), 8'(pl.magnitude));
         end
         want = '0;
      end
      load(8'h51, 8'h32);
      arm();
      want = stim(3'h1);
      wait_on(1'b1);
      cmp8("held", {5'h0, LINE_VOLTAGE}, {5'h0, ml.mode});
      cmp8("apply time", 8'h01, {7'h0, n <= 8});
      want = '0;
      wait_on(1'b0);
      cmp8("hold time", 8'h01, {7'h0, n - 5 * CPM inside {[0:3]}});
      cmp8("removed", {5'h0, LINE_OPEN}, {5'h0, ml.mode});
      cmp8("busy", 8'h00, {7'h0, busy});
      conclude();
   end
endmodule
`default_nettype wire
